// ---- logic/bmsq_pkg.sv ----
// bmsq_pkg: shared constants, states and bus carriers of the master sequencer
// assumes a single 40 MHz system clock; bus lines are wired-low outside
package bmsq_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_PERIOD_NS  = 25;
  // bus clock period, plain default
  localparam int BUS_PERIOD_NS  = 100;
  localparam int BUS_HALF_CYC   = (BUS_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int ARB_SETTLE_CYC = 2;
  localparam int TIMEOUT_STATES = 16;

  // ****************************************************************
  // transfer mode codes
  // ****************************************************************
  localparam logic [1:0] TM_ATTN_NULL  = 2'h3;
  localparam logic [1:0] TM_ATTN_LOCK  = 2'h2;
  localparam logic [1:0] SLV_STATUS_OK = 2'h3;
  localparam int         TM_DIR_BIT    = 1;
  localparam logic [3:0] ARB_ID_RST    = 4'h0;

  typedef enum logic [3:0] {
    S_IDLE, S_ARB, S_FROZEN, S_START, S_DATA, S_CHECK, S_HOLD, S_PARK, S_ATTN
  } bmsq_state_t;

  typedef struct packed {
    logic        rqst;
    logic        start;
    logic        ack;
    logic [1:0]  tm;
    logic [3:0]  arb;
    logic [31:0] ad;
  } bmsq_bus_in_t;

  typedef struct packed {
    logic        rqst_o;
    logic        rqst_oe;
    logic        start_o;
    logic        start_oe;
    logic        ack_o;
    logic        ack_oe;
    logic [1:0]  tm_o;
    logic        tm_oe;
    logic [3:0]  arb_o;
    logic [3:0]  arb_oe;
    logic [31:0] ad_o;
    logic        ad_oe;
  } bmsq_bus_out_t;

endpackage

// ---- logic/bmsq_phase.sv ----
// bmsq_phase: derives bus clock and its driving and sample enables
// assumes the system clock is the only clock
`timescale 1ns/1ps
module bmsq_phase #(
  parameter int HALF_CYC = bmsq_pkg::BUS_HALF_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  output logic      bus_clk_o,
  output logic      drive_en_o,
  output logic      sample_en_o
);
  import bmsq_pkg::*;

  if (HALF_CYC < 1 || HALF_CYC > 256) $error("bmsq_phase: HALF_CYC out of range");

  logic [7:0] cnt_reg;
  logic       phase_reg;
  logic       wrap;

  assign wrap        = (cnt_reg == 8'(HALF_CYC - 1));
  // rising bus edge drives, falling bus edge samples
  assign drive_en_o  = wrap && !phase_reg;
  assign sample_en_o = wrap && phase_reg;
  assign bus_clk_o   = phase_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      cnt_reg   <= 8'h00;
      phase_reg <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_reg   <= 8'h00;
      phase_reg <= !phase_reg;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule

// ---- logic/bmsq_timeout.sv ----
// bmsq_timeout: frozen-state timer counting bus sample edges
// assumes sample_en_i is a one-cycle pulse per bus clock
`timescale 1ns/1ps
module bmsq_timeout #(
  parameter int STATES = bmsq_pkg::TIMEOUT_STATES
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic sample_en_i,
  input  wire logic run_i,
  output logic      done_o
);
  import bmsq_pkg::*;

  if (STATES < 2 || STATES > 255) $error("bmsq_timeout: STATES out of range");

  logic [7:0] cnt_reg;

  assign done_o = (cnt_reg == 8'(STATES));

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !run_i)
      cnt_reg <= 8'h00;
    else if (sample_en_i && !done_o)
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule

// ---- logic/bmsq_sequencer.sv ----
// bmsq_sequencer: master sequencing and slave handshake of a backplane interface
// assumes local inputs synchronous to clk_sys_i; bus pins resolved outside
`timescale 1ns/1ps

// Summary of operation
// - request low starts arbitration, RQST driven
// - first sample after request latches transfer code
// - winner waits until all requesters served
// - mastership flag high from win until lost
// - ready low after win: start next drive
// - write data follows start, then await ACK
// - slave ACK raises master done flag
// - park as master until another arbitrates
// - no hold: automatic next start, same code
// - request or ready high blocks auto start
// - hold low after ACK blocks auto start
// - lock requested: Attention Lock after winning
// - RQST held low during locked sequence
// - lock released: Attention Null, then park
// - ready high at win freezes, arbitration held
// - slave request, grant enables, ack answers
// - 16 frozen states force Attention Null
// - withdrawn request during arbitration: Attention Null
// - status latched at ACK, held till next
module bmsq_sequencer #(
  parameter logic [3:0] ARB_ID         = bmsq_pkg::ARB_ID_RST,
  parameter int         TIMEOUT_STATES = bmsq_pkg::TIMEOUT_STATES,
  parameter int         ARB_SETTLE     = bmsq_pkg::ARB_SETTLE_CYC
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   local_bus_request_n_i,
  input  wire logic                   master_ready_n_i,
  input  wire logic                   master_hold_n_i,
  input  wire logic                   lock_request_n_i,
  input  wire logic [1:0]             local_transfer_code_i,
  input  wire logic [31:0]            master_addr_i,
  input  wire logic [31:0]            master_wdata_i,
  output logic                        mastership_flag_o,
  output logic                        master_done_flag_o,
  output logic [31:0]                 master_rdata_o,
  output logic [1:0]                  master_status_o,
  input  wire logic                   slave_id_match_i,
  input  wire logic                   slave_grant_n_i,
  input  wire logic                   local_ack_n_i,
  input  wire logic [31:0]            slave_rdata_i,
  output logic                        slave_access_request_n_o,
  output logic                        slave_bus_en_o,
  output logic [31:0]                 slave_addr_o,
  output logic [31:0]                 slave_wdata_o,
  output logic [1:0]                  slave_tm_o,
  input  wire bmsq_pkg::bmsq_bus_in_t bus_i,
  output bmsq_pkg::bmsq_bus_out_t     bus_o,
  output logic                        bus_clk_o
);
  import bmsq_pkg::*;

  if (ARB_SETTLE < 1 || ARB_SETTLE > 15) $error("bmsq_sequencer: ARB_SETTLE out of range");

  // ****************************************************************
  // helpers
  // ****************************************************************
  // arbitration contest: drop lower id bits once a higher one is lost
  function automatic logic [3:0] arb_drive(input logic [3:0] id, input logic [3:0] seen);
    logic [3:0] r;
    logic       blk;
    r   = 4'h0;
    blk = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      r[i] = id[i] && !blk;
      if (seen[i] && !id[i])
        blk = 1'b1;
    end
    return r;
  endfunction

  // first master action after gaining the bus
  function automatic bmsq_state_t pick(input logic abort, input logic lock, input logic rdy_n);
    if (abort || lock)
      return S_ATTN;
    else if (rdy_n)
      return S_FROZEN;
    else
      return S_START;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  bmsq_state_t   st_reg;
  bmsq_bus_out_t bus_reg;
  logic          drive_en;
  logic          sample_en;
  logic          tmo_done;
  logic          mstr_reg;
  logic          done_reg;
  logic          fair_reg;
  logic          abort_reg;
  logic          drop_reg;
  logic          attn_lock_reg;
  logic          lock_mode_reg;
  logic          busy_reg;
  logic [3:0]    arb_cnt_reg;
  logic          req_seen_reg;
  logic          lock_req_reg;
  logic [1:0]    code_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    status_reg;
  logic          s_act_reg;
  logic          s_pend_reg;
  logic          s_acked_reg;
  logic          s_ack_reg;
  logic          s_en_reg;
  logic [31:0]   s_addr_reg;
  logic [31:0]   s_data_reg;
  logic [1:0]    s_tm_reg;
  logic          req_n;
  logic          lock_now;
  logic          won;
  logic          is_write;

  assign req_n    = local_bus_request_n_i;
  // lock level as seen at the edge that takes the request
  assign lock_now = req_seen_reg ? lock_req_reg : !lock_request_n_i;
  assign won      = (arb_cnt_reg >= 4'(ARB_SETTLE - 1)) && !busy_reg && (~bus_i.arb == ARB_ID);
  assign is_write = !code_reg[TM_DIR_BIT];

  bmsq_phase u_phase (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .bus_clk_o   (bus_clk_o),
    .drive_en_o  (drive_en),
    .sample_en_o (sample_en)
  );

  bmsq_timeout #(
    .STATES (TIMEOUT_STATES)
  ) u_timeout (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .sample_en_i (sample_en),
    .run_i       (st_reg == S_FROZEN && !req_n && master_ready_n_i),
    .done_o      (tmo_done)
  );

  // ****************************************************************
  // request sampling
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      req_seen_reg <= 1'b0;
      lock_req_reg <= 1'b0;
      code_reg     <= 2'h0;
    end
    else if (sample_en)
    begin
      req_seen_reg <= !req_n;
      // code taken at first sample of a request
      // a release seen at one sample edge lets a new code in
      if (!req_n && !req_seen_reg)
      begin
        code_reg     <= local_transfer_code_i;
        lock_req_reg <= !lock_request_n_i;
      end
    end
  end

  // ****************************************************************
  // bus occupancy and fairness
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      busy_reg <= 1'b0;
      fair_reg <= 1'b0;
    end
    else if (sample_en)
    begin
      if (!bus_i.ack)
        busy_reg <= 1'b0;
      else if (!bus_i.start && !mstr_reg)
        busy_reg <= 1'b1;
      // no new contest until the request line is seen free
      if (st_reg == S_ARB && won)
        fair_reg <= 1'b1;
      else if (bus_i.rqst && !bus_reg.rqst_oe)
        fair_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // master state machine
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      st_reg        <= S_IDLE;
      mstr_reg      <= 1'b0;
      done_reg      <= 1'b0;
      abort_reg     <= 1'b0;
      drop_reg      <= 1'b0;
      attn_lock_reg <= 1'b0;
      lock_mode_reg <= 1'b0;
      arb_cnt_reg   <= 4'h0;
      rdata_reg     <= 32'h0;
      status_reg    <= 2'h0;
    end
    else if (sample_en)
    begin
      case (st_reg)
        S_IDLE:
        begin
          arb_cnt_reg <= 4'h0;
          abort_reg   <= 1'b0;
          if (!req_n && !fair_reg)
            st_reg <= S_ARB;
        end
        S_ARB:
        begin
          if (arb_cnt_reg != 4'hf)
            arb_cnt_reg <= arb_cnt_reg + 4'h1;
          if (req_n)
            abort_reg <= 1'b1;
          if (won)
          begin
            // mastership flag raised on the win
            mstr_reg      <= 1'b1;
            // not ready freezes with arbitration held
            st_reg        <= pick(abort_reg || req_n, lock_req_reg, master_ready_n_i);
            attn_lock_reg <= !(abort_reg || req_n) && lock_req_reg;
            lock_mode_reg <= !(abort_reg || req_n) && lock_req_reg;
            drop_reg      <= abort_reg || req_n;
          end
        end
        S_FROZEN:
        begin
          // timeout or withdrawal ends with a null cycle
          if (tmo_done || req_n)
          begin
            st_reg        <= S_ATTN;
            attn_lock_reg <= 1'b0;
            lock_mode_reg <= 1'b0;
            drop_reg      <= 1'b1;
          end
          else if (!master_ready_n_i)
            st_reg <= S_START;
        end
        S_START:
          st_reg <= S_DATA;
        S_DATA:
          // status kept until the next acknowledge
          if (!bus_i.ack)
          begin
            done_reg   <= 1'b1;
            status_reg <= bus_i.tm;
            if (!is_write)
              rdata_reg <= bus_i.ad;
            st_reg <= S_CHECK;
          end
        S_CHECK:
          // back-to-back start with the held code
          // request or ready released stops it
          if (!req_n && !master_ready_n_i && master_hold_n_i && (lock_mode_reg || bus_i.rqst))
          begin
            done_reg <= 1'b0;
            st_reg   <= S_START;
          end
          // released request with hold off returns straight to park
          else if (req_n && master_hold_n_i)
          begin
            done_reg <= 1'b0;
            st_reg   <= S_PARK;
          end
          else
            st_reg <= S_HOLD;
        S_HOLD:
          if (req_n && master_hold_n_i)
          begin
            done_reg <= 1'b0;
            st_reg   <= S_PARK;
          end
        S_PARK:
          if (lock_mode_reg && lock_request_n_i)
          begin
            st_reg        <= S_ATTN;
            attn_lock_reg <= 1'b0;
            lock_mode_reg <= 1'b0;
            drop_reg      <= 1'b0;
          end
          // park ends when another master contends
          else if (!lock_mode_reg && !bus_i.rqst)
          begin
            mstr_reg <= 1'b0;
            st_reg   <= S_IDLE;
          end
          else if (!req_n)
          begin
            st_reg        <= pick(1'b0, lock_now && !lock_mode_reg, master_ready_n_i);
            attn_lock_reg <= lock_now && !lock_mode_reg;
            lock_mode_reg <= lock_mode_reg || lock_now;
            drop_reg      <= 1'b0;
          end
        S_ATTN:
          if (drop_reg)
          begin
            mstr_reg <= 1'b0;
            st_reg   <= S_IDLE;
          end
          else
            st_reg <= S_PARK;
        default:
          st_reg <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // slave handshake
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_act_reg   <= 1'b0;
      s_pend_reg  <= 1'b0;
      s_acked_reg <= 1'b0;
      s_ack_reg   <= 1'b0;
      s_en_reg    <= 1'b0;
      s_addr_reg  <= 32'h0;
      s_data_reg  <= 32'h0;
      s_tm_reg    <= 2'h0;
    end
    else
    begin
      if (sample_en)
      begin
        if (!s_act_reg)
        begin
          if (!bus_i.start && bus_i.ack && slave_id_match_i && !mstr_reg)
          begin
            s_act_reg  <= 1'b1;
            s_addr_reg <= bus_i.ad;
            s_tm_reg   <= bus_i.tm;
          end
        end
        else
        begin
          // grant gates the local path, ack answers
          s_en_reg <= !slave_grant_n_i;
          if (!s_acked_reg && !s_pend_reg)
            s_data_reg <= bus_i.ad;
          if (!local_ack_n_i && !s_acked_reg)
            s_pend_reg <= 1'b1;
          if (s_acked_reg && slave_grant_n_i)
          begin
            s_act_reg   <= 1'b0;
            s_acked_reg <= 1'b0;
          end
        end
      end
      if (drive_en)
      begin
        s_ack_reg <= s_pend_reg;
        if (s_pend_reg)
        begin
          s_pend_reg  <= 1'b0;
          s_acked_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // bus drivers, updated on the driving edge only
  // ****************************************************************
  // outputs move on drive edges, inputs taken on sample edges
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      bus_reg <= '0;
    else if (drive_en)
    begin
      bus_reg <= '0;
      // lock keeps the request line low
      bus_reg.rqst_oe <= (st_reg == S_ARB) || (st_reg == S_FROZEN) || (lock_mode_reg && mstr_reg);
      if (st_reg == S_ARB || st_reg == S_FROZEN)
        bus_reg.arb_oe <= arb_drive(ARB_ID, ~bus_i.arb);
      bus_reg.start_oe <= (st_reg == S_START) || (st_reg == S_ATTN);
      bus_reg.ack_oe   <= (st_reg == S_ATTN) || s_pend_reg;
      if (st_reg == S_START)
      begin
        bus_reg.tm_o  <= code_reg;
        bus_reg.tm_oe <= 1'b1;
        bus_reg.ad_o  <= master_addr_i;
        bus_reg.ad_oe <= 1'b1;
      end
      else if (st_reg == S_ATTN)
      begin
        bus_reg.tm_o  <= attn_lock_reg ? TM_ATTN_LOCK : TM_ATTN_NULL;
        bus_reg.tm_oe <= 1'b1;
      end
      // write data once the start cycle ends
      else if (st_reg == S_DATA && is_write)
      begin
        bus_reg.ad_o  <= master_wdata_i;
        bus_reg.ad_oe <= 1'b1;
      end
      else if (s_pend_reg)
      begin
        bus_reg.tm_o  <= SLV_STATUS_OK;
        bus_reg.tm_oe <= 1'b1;
        bus_reg.ad_o  <= slave_rdata_i;
        bus_reg.ad_oe <= s_tm_reg[TM_DIR_BIT];
      end
    end
  end

  assign bus_o                    = bus_reg;
  assign mastership_flag_o        = mstr_reg;
  assign master_done_flag_o       = done_reg;
  assign master_rdata_o           = rdata_reg;
  assign master_status_o          = status_reg;
  assign slave_access_request_n_o = !s_act_reg;
  assign slave_bus_en_o           = s_en_reg;
  assign slave_addr_o             = s_addr_reg;
  assign slave_wdata_o            = s_data_reg;
  assign slave_tm_o               = s_tm_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_ARB_RQST: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    drive_en && st_reg == S_ARB |=> bus_o.rqst_oe)
    else $error("request line not driven while contending");
  AST_MSTR_HELD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st_reg inside {S_START, S_DATA, S_CHECK, S_HOLD, S_PARK} |-> mastership_flag_o)
    else $error("mastership flag low during own tenure");
  AST_START_DRIVEN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_en && st_reg == S_START |-> bus_o.start_oe && bus_o.ad_oe && !bus_o.ack_oe)
    else $error("start cycle missing at its sample edge");
  AST_DONE_ON_ACK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_en && st_reg == S_DATA && !bus_i.ack |=> master_done_flag_o ##1 st_reg == S_CHECK)
    else $error("done flag not raised on acknowledge");
  AST_NO_AUTO_REQ: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_en && st_reg == S_CHECK && (req_n || master_ready_n_i) |=> st_reg inside {S_HOLD, S_PARK})
    else $error("automatic start despite released request");
  AST_NO_AUTO_HOLD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_en && st_reg == S_CHECK && !master_hold_n_i |=> st_reg != S_START)
    else $error("automatic start despite hold");
  AST_LOCK_RQST: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    lock_mode_reg && mstr_reg && $past(drive_en) && $past(lock_mode_reg) |-> bus_o.rqst_oe)
    else $error("request line released inside locked sequence");
  AST_TIMEOUT_NULL: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_en && st_reg == S_FROZEN && tmo_done |=> st_reg == S_ATTN && !attn_lock_reg)
    else $error("timeout did not force a null cycle");
  AST_SLV_ACK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    drive_en && s_pend_reg |=> bus_o.ack_oe && bus_o.tm_o == SLV_STATUS_OK)
    else $error("slave acknowledge not issued on drive edge");
  AST_DRIVE_EDGE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $changed(bus_o.start_oe) |-> $past(drive_en))
    else $error("start line moved off a driving edge");
endmodule

// ---- tb/bmsq_far_model.sv ----
// bmsq_far_model: bus side stand-in, one slave and one contending master
// assumes open-drain lines pulled high and bus_clk_i from the sequencer
`timescale 1ns/1ps
module bmsq_far_model (
  input  wire logic                    clk_sys_i,
  input  wire logic                    bus_clk_i,
  input  wire bmsq_pkg::bmsq_bus_out_t dut_i,
  input  wire logic                    contend_i,
  input  wire logic [1:0]              ack_wait_i,
  input  wire logic [31:0]             rdata_i,
  output bmsq_pkg::bmsq_bus_in_t       bus_o,
  output logic [7:0]                   starts_o,
  output logic [7:0]                   locks_o,
  output logic [7:0]                   nulls_o,
  output logic [1:0]                   tm_o,
  output logic [31:0]                  wdata_o
);
  import bmsq_pkg::*;
  logic       ack_drv;
  logic       go;
  logic       tgl;
  logic [1:0] wt;
  initial
  begin
    {ack_drv, go, tgl, wt, starts_o, locks_o, nulls_o, tm_o, wdata_o} = '0;
  end
  always @(posedge clk_sys_i) tgl <= ~tgl;
  // ****************************************************************
  // wire resolution, released data lines toggle
  // ****************************************************************
  // contender drives its id on the arbitration lines
  assign bus_o.rqst  = ~(dut_i.rqst_oe | contend_i);
  assign bus_o.arb   = ~(dut_i.arb_oe | {1'b0, contend_i, 1'b0, contend_i});
  assign bus_o.start = ~dut_i.start_oe;
  assign bus_o.ack   = ~(dut_i.ack_oe | ack_drv);
  assign bus_o.tm    = dut_i.tm_oe ? dut_i.tm_o : ack_drv ? SLV_STATUS_OK : {tgl, ~tgl};
  assign bus_o.ad    = dut_i.ad_oe ? dut_i.ad_o : ack_drv ? rdata_i : {16{tgl, ~tgl}};
  always @(negedge bus_clk_i)
  begin
    if (!bus_o.start && !bus_o.ack)
    begin
      if (bus_o.tm == TM_ATTN_LOCK) locks_o <= locks_o + 8'h01;
      if (bus_o.tm == TM_ATTN_NULL) nulls_o <= nulls_o + 8'h01;
    end
    else if (!bus_o.start)
    begin
      starts_o <= starts_o + 8'h01;
      tm_o     <= bus_o.tm;
      go       <= 1'b1;
      wt       <= ack_wait_i;
    end
    else if (go || ack_drv)
      wdata_o <= bus_o.ad;
  end
  // slave answers on the driving edge for one bus period
  always @(posedge bus_clk_i)
  begin
    if (ack_drv)
      ack_drv <= 1'b0;
    else if (go && wt == 2'h0)
    begin
      ack_drv <= 1'b1;
      go      <= 1'b0;
    end
    else if (go)
      wt <= wt - 2'h1;
  end
endmodule

// ---- tb/test_backplane_master_sequencer.sv ----
// test_backplane_master_sequencer: scenarios for the master sequencer
// assumes the far model stands for all other boards on the bus
`timescale 1ns/1ps
module test_backplane_master_sequencer;
  import bmsq_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_n = 1'b1, rdy_n = 1'b1, hold_n = 1'b1, lock_n = 1'b1, contend = 1'b0;
  logic [1:0] code = 2'h0, ack_wait = 2'h1, far_tm, status;
  logic [31:0] wdata = 32'hc3a5_0f96, mrdata = 32'h5a5a_1234, rdata, far_wd;
  logic mst, done, bus_clk;
  logic [7:0] starts, locks, nulls, s, n;
  bmsq_bus_in_t bus_in;
  bmsq_bus_out_t bus_out;
  int mismatches = 0, cmp_count = 0, cycles = 0, k;
  always #12.5 clk_sys_i = ~clk_sys_i;
  bmsq_sequencer dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .local_bus_request_n_i(req_n), .master_ready_n_i(rdy_n), .master_hold_n_i(hold_n),
    .lock_request_n_i(lock_n), .local_transfer_code_i(code), .master_addr_i(32'h0010_0040),
    .master_wdata_i(wdata), .mastership_flag_o(mst), .master_done_flag_o(done),
    .master_rdata_o(rdata), .master_status_o(status), .slave_id_match_i(1'b0),
    .slave_grant_n_i(1'b1), .local_ack_n_i(1'b1), .slave_rdata_i(32'h0),
    .slave_access_request_n_o(), .slave_bus_en_o(), .slave_addr_o(), .slave_wdata_o(),
    .slave_tm_o(), .bus_i(bus_in), .bus_o(bus_out), .bus_clk_o(bus_clk));
  bmsq_far_model far_u (.clk_sys_i(clk_sys_i), .bus_clk_i(bus_clk), .dut_i(bus_out),
    .contend_i(contend), .ack_wait_i(ack_wait), .rdata_i(mrdata), .bus_o(bus_in),
    .starts_o(starts), .locks_o(locks), .nulls_o(nulls), .tm_o(far_tm), .wdata_o(far_wd));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task print_verdict;
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic set_loc(input logic r, y, h, l, input logic [1:0] c);
    @(posedge clk_sys_i);
    #2;
    {req_n, rdy_n, hold_n, lock_n, code} = {r, y, h, l, c};
  endtask
  task automatic wait_on(input bit sel, input logic v);
    k = 0;
    while (((sel ? done : mst) !== v) && k < 400)
    begin
      @(posedge clk_sys_i);
      k++;
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys_i);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_read_park;
    set_loc(1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
    wait_on(1'b0, 1'b1);
    wait_on(1'b1, 1'b1);
    chk("rdata", mrdata, rdata);
    chk("status", {30'h0, SLV_STATUS_OK}, {30'h0, status});
    chk("tm", 32'h2, {30'h0, far_tm});
    // request kept low past the check edge: only hold stops a restart
    idle(4);
    set_loc(1'b1, 1'b1, 1'b1, 1'b1, 2'h2);
    idle(30);
    chk("starts", 32'h1, {24'h0, starts});
    chk("park", 32'h1, {31'h0, mst});
  endtask
  task automatic sc_write_parked;
    s = starts;
    ack_wait = 2'h0;
    set_loc(1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
    wait_on(1'b1, 1'b1);
    chk("wdata", wdata, far_wd);
    chk("tm", 32'h0, {30'h0, far_tm});
    chk("starts", {24'h0, s + 8'h01}, {24'h0, starts});
    set_loc(1'b1, 1'b1, 1'b1, 1'b1, 2'h0);
    ack_wait = 2'h1;
    idle(20);
  endtask
  task automatic sc_auto;
    s = starts;
    set_loc(1'b0, 1'b0, 1'b1, 1'b1, 2'h2);
    wait_on(1'b1, 1'b1);
    idle(40);
    chk("auto", 32'h1, {31'h0, (starts - s) >= 8'h03});
    wait_on(1'b1, 1'b0);
    wait_on(1'b1, 1'b1);
    // one bus period of released request brings in a write code
    set_loc(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
    idle(3);
    set_loc(1'b0, 1'b0, 1'b1, 1'b1, 2'h0);
    wait_on(1'b1, 1'b0);
    wait_on(1'b1, 1'b1);
    chk("recode", 32'h0, {30'h0, far_tm});
    set_loc(1'b1, 1'b1, 1'b1, 1'b1, 2'h2);
    idle(20);
    s = starts;
    idle(40);
    chk("stop", {24'h0, s}, {24'h0, starts});
  endtask
  task automatic sc_contend;
    #2 contend = 1'b1;
    wait_on(1'b0, 1'b0);
    chk("lost", 32'h0, {31'h0, mst});
    #2 contend = 1'b0;
    idle(20);
  endtask
  task automatic sc_lock;
    s = locks;
    n = nulls;
    set_loc(1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
    wait_on(1'b1, 1'b1);
    chk("lock", {24'h0, s + 8'h01}, {24'h0, locks});
    set_loc(1'b1, 1'b1, 1'b1, 1'b0, 2'h2);
    idle(20);
    chk("rqst", 32'h1, {31'h0, bus_out.rqst_oe});
    set_loc(1'b1, 1'b1, 1'b1, 1'b1, 2'h2);
    idle(30);
    chk("null", {24'h0, n + 8'h01}, {24'h0, nulls});
    chk("park", 32'h1, {31'h0, mst});
  endtask
  task automatic sc_timeout;
    n = nulls;
    set_loc(1'b0, 1'b1, 1'b0, 1'b1, 2'h2);
    wait_on(1'b0, 1'b1);
    idle(8);
    chk("frozen_rqst", 32'h1, {31'h0, bus_out.rqst_oe});
    wait_on(1'b0, 1'b0);
    chk("frozen_lo", 32'h1, {31'h0, k + 9 >= 4 * TIMEOUT_STATES});
    chk("frozen_hi", 32'h1, {31'h0, k <= 4 * TIMEOUT_STATES + 3});
    idle(8);
    chk("null", {24'h0, n + 8'h01}, {24'h0, nulls});
    set_loc(1'b1, 1'b1, 1'b1, 1'b1, 2'h2);
    idle(20);
  endtask
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict;
    end
  end
  initial
  begin
    idle(4);
    #2 sys_rst_i = 1'b0;
    sc_read_park;
    sc_write_parked;
    sc_auto;
    sc_contend;
    sc_lock;
    sc_contend;
    sc_timeout;
    print_verdict;
  end
endmodule
